// file: core/fos_consts.svh
/*
 Offsets, field positions, reset values and timing counts of the flash operation sequencer.
 Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
// Function
// - Program suspend raises operation-complete within 11.5 us plus four clocks.
// - Erase suspend raises operation-complete within 20.8 us plus four clocks.
// - Clearing suspend with high voltage on resumes and drops complete within 100 ns.
// - High voltage enable rising starts program or erase, clears complete within 5 ns.
// - High voltage enable falling aborts; complete rises within 20.8 us plus four clocks.
// - Low-power exit needs at most 45 us plus seven clocks recovery.
// - Check enable rising, or clearing suspend/breakpoint, clears check-done within 5 ns.
// - Integrity check abort or suspend sets check-done within 80 ns plus fifteen clocks.
// - Margin read abort or suspend sets check-done in 10.36 to 20.42 us plus four.
// - Cache miss read takes 3 clocks plus the wait states (3, 5 or 6 at 0, 2 or 3); cache hit takes one.
`ifndef FOS_CONSTS_SVH
`define FOS_CONSTS_SVH

`define FOS_CLK_NS 10

`define FOS_ADDR_MCW 12'h000
`define FOS_ADDR_UTW 12'h004
`define FOS_ADDR_RCW 12'h008
`define FOS_ADDR_RDA 12'h00C
`define FOS_ADDR_RDS 12'h010

`define FOS_MCW_HV 0
`define FOS_MCW_PSUS 1
`define FOS_MCW_ESUS 2
`define FOS_MCW_ERASE 3
`define FOS_MCW_LPM 4
`define FOS_MCW_DONE 8
`define FOS_MCW_READY 9
`define FOS_MCW_WMASK 32'h0000001F

`define FOS_UTW_EN 0
`define FOS_UTW_SUS 1
`define FOS_UTW_NBP 2
`define FOS_UTW_MARGIN 3
`define FOS_UTW_DONE 8
`define FOS_UTW_WMASK 32'h0000000F

`define FOS_RCW_WS_LSB 0
`define FOS_RCW_AP_LSB 4
`define FOS_RCW_WMASK 32'h00000033
`define FOS_RCW_RESET 32'h00000021

`define FOS_PSUS_TYP_NS 9400
`define FOS_PSUS_CLKS 4
`define FOS_ESUS_TYP_NS 16000
`define FOS_ESUS_CLKS 4
`define FOS_ABORT_TYP_NS 16000
`define FOS_ABORT_CLKS 4
`define FOS_LPR_MAX_NS 45000
`define FOS_LPR_CLKS 7
`define FOS_AISTOP_MAX_NS 80
`define FOS_AISTOP_CLKS 15
`define FOS_MRSTOP_MIN_NS 10360
`define FOS_MRSTOP_CLKS 4
`define FOS_HIT_CLKS 1
`define FOS_MISS_BASE_CLKS 3

`define FOS_PSUS_CYC (`FOS_PSUS_TYP_NS / `FOS_CLK_NS + `FOS_PSUS_CLKS)
`define FOS_ESUS_CYC (`FOS_ESUS_TYP_NS / `FOS_CLK_NS + `FOS_ESUS_CLKS)
`define FOS_ABORT_CYC (`FOS_ABORT_TYP_NS / `FOS_CLK_NS + `FOS_ABORT_CLKS)
`define FOS_LPR_CYC (`FOS_LPR_MAX_NS / `FOS_CLK_NS + `FOS_LPR_CLKS)
`define FOS_AISTOP_CYC (`FOS_AISTOP_MAX_NS / `FOS_CLK_NS + `FOS_AISTOP_CLKS)
`define FOS_MRSTOP_CYC ((`FOS_MRSTOP_MIN_NS + `FOS_CLK_NS - 1) / `FOS_CLK_NS + `FOS_MRSTOP_CLKS)

`define FOS_PROG_CYC 2000
`define FOS_ERASE_CYC 4000
`define FOS_CHECK_CYC 3000

`define FOS_RESP_OKAY 2'b00
`define FOS_RESP_DECERR 2'b11

`endif

// file: core/fos_pkg.sv
/*
 Types of the flash operation sequencer.
 Assumes the constants header is compiled alongside.
*/
package fos_pkg;
	typedef enum logic [4:0] {
		FOS_OP_IDLE = 5'b00001,
		FOS_OP_RUN = 5'b00010,
		FOS_OP_SUSPENDING = 5'b00100,
		FOS_OP_SUSPENDED = 5'b01000,
		FOS_OP_ABORTING = 5'b10000
	} fos_op_state_t;

	typedef enum logic [3:0] {
		FOS_CK_IDLE = 4'b0001,
		FOS_CK_RUN = 4'b0010,
		FOS_CK_STOPPING = 4'b0100,
		FOS_CK_HELD = 4'b1000
	} fos_ck_state_t;

	typedef logic [31:0] fos_word_t;
	typedef logic [15:0] fos_count_t;
endpackage

// file: core/fos_timer.sv
/*
 Down-counting interval timer with a one-cycle expiry pulse.
 Assumes load and cancel come from logic on the same clock.
*/
module fos_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic cancel,
	input wire fos_pkg::fos_count_t load_val,
	output logic expired,
	output logic busy
);
	import fos_pkg::*;

	fos_count_t cnt_reg;
	logic busy_reg;
	logic exp_reg;
	wire logic last_tick = busy_reg & (cnt_reg == 16'h0001);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= 16'h0000;
			busy_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			exp_reg <= last_tick & ~load & ~cancel;
			if (load) begin
				cnt_reg <= load_val;
				busy_reg <= 1'b1;
			end else if (cancel | last_tick) begin
				busy_reg <= 1'b0;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 16'h0001;
			end
		end
	end

	assign expired = exp_reg;
	assign busy = busy_reg;
endmodule

// file: core/fos_top.sv
/*
 Flash operation sequencer: program/erase with suspend and abort, integrity and margin checks,
 low-power recovery and a read latency model with a one-line read cache, behind AXI4-Lite.
 Assumes software follows the wait-state recommendations for the platform clock.
*/
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`include "fos_consts.svh"

module fos_top #(
	parameter int LPR_CYC = `FOS_LPR_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire fos_pkg::fos_word_t s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output fos_pkg::fos_word_t s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic op_done,
	output logic check_done,
	output logic flash_ready
);
	import fos_pkg::*;

	function automatic fos_word_t merge(input fos_word_t old_v, input fos_word_t new_v, input logic [3:0] strb,
		input fos_word_t wmask);
		fos_word_t m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
		return (old_v & ~m) | (new_v & m);
	endfunction

	function automatic fos_count_t ld(input int cyc);
		return 16'(cyc - 1);
	endfunction

	// Bus slave state
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [11:0] awaddr_reg;
	fos_word_t wdata_reg, rdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;

	// Register, sequencer and read engine state
	fos_word_t mcw_reg, utw_reg, rcw_reg, rda_reg;
	logic op_done_reg, ck_done_reg, ready_reg;
	fos_op_state_t op_reg;
	fos_ck_state_t ck_reg;
	logic [12:0] lpr_reg;
	logic [27:0] tag_reg;
	logic tag_valid_reg, rd_busy_reg, rd_hit_reg;
	logic [3:0] rd_cnt_reg, rd_lat_reg;

	// Write decode
	wire logic aw_taken = s_axi_awvalid & awready_reg;
	wire logic w_taken = s_axi_wvalid & wready_reg;
	wire logic wr_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;
	wire logic wr_mcw = wr_fire & (awaddr_reg == `FOS_ADDR_MCW);
	wire logic wr_utw = wr_fire & (awaddr_reg == `FOS_ADDR_UTW);
	wire logic wr_rcw = wr_fire & (awaddr_reg == `FOS_ADDR_RCW);
	wire logic wr_rda = wr_fire & (awaddr_reg == `FOS_ADDR_RDA);
	wire logic wr_hit = wr_mcw | wr_utw | wr_rcw | wr_rda | (awaddr_reg == `FOS_ADDR_RDS);

	wire fos_word_t mcw_next = wr_mcw ? merge(mcw_reg, wdata_reg, wstrb_reg, `FOS_MCW_WMASK) : mcw_reg;
	wire fos_word_t utw_next = wr_utw ? merge(utw_reg, wdata_reg, wstrb_reg, `FOS_UTW_WMASK) : utw_reg;
	wire fos_word_t rcw_next = wr_rcw ? merge(rcw_reg, wdata_reg, wstrb_reg, `FOS_RCW_WMASK) : rcw_reg;
	wire fos_word_t rda_next = wr_rda ? merge(rda_reg, wdata_reg, wstrb_reg, 32'hFFFFFFFF) : rda_reg;

	// Control bit events
	wire logic hv_rise = ~mcw_reg[`FOS_MCW_HV] & mcw_next[`FOS_MCW_HV];
	wire logic hv_fall = mcw_reg[`FOS_MCW_HV] & ~mcw_next[`FOS_MCW_HV];
	wire logic psus_rise = ~mcw_reg[`FOS_MCW_PSUS] & mcw_next[`FOS_MCW_PSUS];
	wire logic esus_rise = ~mcw_reg[`FOS_MCW_ESUS] & mcw_next[`FOS_MCW_ESUS];
	wire logic sus_clear = (mcw_reg[`FOS_MCW_PSUS] | mcw_reg[`FOS_MCW_ESUS])
		& ~mcw_next[`FOS_MCW_PSUS] & ~mcw_next[`FOS_MCW_ESUS];
	wire logic lpm_fall = mcw_reg[`FOS_MCW_LPM] & ~mcw_next[`FOS_MCW_LPM];
	wire logic en_rise = ~utw_reg[`FOS_UTW_EN] & utw_next[`FOS_UTW_EN];
	wire logic en_fall = utw_reg[`FOS_UTW_EN] & ~utw_next[`FOS_UTW_EN];
	wire logic ck_sus_rise = ~utw_reg[`FOS_UTW_SUS] & utw_next[`FOS_UTW_SUS];
	wire logic ck_resume = ((utw_reg[`FOS_UTW_SUS] & ~utw_next[`FOS_UTW_SUS])
		| (utw_reg[`FOS_UTW_NBP] & ~utw_next[`FOS_UTW_NBP])) & utw_next[`FOS_UTW_EN];
	wire logic margin = utw_reg[`FOS_UTW_MARGIN];
	wire logic usable = ready_reg & ~mcw_reg[`FOS_MCW_LPM];

	// Program/erase sequencing
	logic op_exp, ck_exp;
	fos_op_state_t op_next;
	logic op_load, op_cancel;
	fos_count_t op_val;
	wire fos_count_t op_run_val = mcw_next[`FOS_MCW_ERASE] ? ld(`FOS_ERASE_CYC) : ld(`FOS_PROG_CYC);

	always_comb begin
		op_next = op_reg;
		op_load = 1'b0;
		op_cancel = 1'b0;
		op_val = op_run_val;
		unique case (op_reg)
			FOS_OP_IDLE: begin
				if (hv_rise & usable) begin
					op_next = FOS_OP_RUN;
					op_load = 1'b1;
				end
			end
			FOS_OP_RUN: begin
				if (hv_fall) begin
					op_next = FOS_OP_ABORTING;
					op_load = 1'b1;
					op_val = ld(`FOS_ABORT_CYC);
				end else if (psus_rise) begin
					op_next = FOS_OP_SUSPENDING;
					op_load = 1'b1;
					op_val = ld(`FOS_PSUS_CYC);
				end else if (esus_rise) begin
					op_next = FOS_OP_SUSPENDING;
					op_load = 1'b1;
					op_val = ld(`FOS_ESUS_CYC);
				end else if (op_exp) begin
					op_next = FOS_OP_IDLE;
				end
			end
			FOS_OP_SUSPENDING: begin
				if (op_exp) begin
					op_next = FOS_OP_SUSPENDED;
				end
			end
			FOS_OP_SUSPENDED: begin
				if (~mcw_next[`FOS_MCW_HV]) begin
					op_next = FOS_OP_IDLE;
				end else if (sus_clear) begin
					op_next = FOS_OP_RUN;
					op_load = 1'b1;
				end
			end
			FOS_OP_ABORTING: begin
				if (op_exp) begin
					op_next = FOS_OP_IDLE;
				end
			end
			default: begin
				op_next = FOS_OP_IDLE;
				op_cancel = 1'b1;
			end
		endcase
	end

	// Done flag low exactly while an operation is active
	wire logic op_done_next = (op_next == FOS_OP_IDLE) | (op_next == FOS_OP_SUSPENDED);

	fos_timer u_op_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(op_load),
		.cancel(op_cancel),
		.load_val(op_val),
		.expired(op_exp),
		.busy()
	);

	// Integrity and margin check sequencing
	fos_ck_state_t ck_next;
	logic ck_load, ck_cancel;
	fos_count_t ck_val;
	wire fos_count_t ck_stop_val = margin ? ld(`FOS_MRSTOP_CYC) : ld(`FOS_AISTOP_CYC);

	always_comb begin
		ck_next = ck_reg;
		ck_load = 1'b0;
		ck_cancel = 1'b0;
		ck_val = ld(`FOS_CHECK_CYC);
		unique case (ck_reg)
			FOS_CK_IDLE: begin
				if (en_rise & usable) begin
					ck_next = FOS_CK_RUN;
					ck_load = 1'b1;
				end
			end
			FOS_CK_RUN: begin
				if (en_fall | ck_sus_rise) begin
					ck_next = FOS_CK_STOPPING;
					ck_load = 1'b1;
					ck_val = ck_stop_val;
				end else if (ck_exp) begin
					ck_next = FOS_CK_IDLE;
				end
			end
			FOS_CK_STOPPING: begin
				if (ck_exp) begin
					ck_next = (utw_reg[`FOS_UTW_SUS] & utw_reg[`FOS_UTW_EN]) ? FOS_CK_HELD : FOS_CK_IDLE;
				end
			end
			FOS_CK_HELD: begin
				if (~utw_next[`FOS_UTW_EN]) begin
					ck_next = FOS_CK_IDLE;
				end else if (ck_resume & ~utw_next[`FOS_UTW_SUS]) begin
					ck_next = FOS_CK_RUN;
					ck_load = 1'b1;
				end
			end
			default: begin
				ck_next = FOS_CK_IDLE;
				ck_cancel = 1'b1;
			end
		endcase
	end

	wire logic ck_done_next = (ck_next == FOS_CK_IDLE) | (ck_next == FOS_CK_HELD);

	fos_timer u_ck_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(ck_load),
		.cancel(ck_cancel),
		.load_val(ck_val),
		.expired(ck_exp),
		.busy()
	);

	// Low-power recovery
	wire logic lpr_last = ~ready_reg & (lpr_reg == 13'h0001);
	wire logic ready_next = mcw_next[`FOS_MCW_LPM] ? 1'b0 : (lpm_fall ? 1'b0 : (ready_reg | lpr_last));
	wire logic [12:0] lpr_next = lpm_fall ? 13'(LPR_CYC) : ((lpr_reg != 13'h0000) ? lpr_reg - 13'h0001 : lpr_reg);

	// Read latency model with a one-line cache
	wire logic [3:0] wait_states = rcw_reg[`FOS_RCW_WS_LSB +: 4];
	wire logic rd_start = wr_rda & ~rd_busy_reg;
	wire logic rd_hit = tag_valid_reg & (tag_reg == rda_next[31:4]);
	wire logic [3:0] rd_lat = rd_hit ? 4'(`FOS_HIT_CLKS) : wait_states + 4'(`FOS_MISS_BASE_CLKS);

	// Read decode
	wire logic [11:0] ar_a = s_axi_araddr;
	wire logic ar_taken = s_axi_arvalid & arready_reg;
	wire fos_word_t mcw_view = mcw_reg | ({31'h00000000, op_done_reg} << `FOS_MCW_DONE)
		| ({31'h00000000, ready_reg} << `FOS_MCW_READY);
	wire fos_word_t utw_view = utw_reg | ({31'h00000000, ck_done_reg} << `FOS_UTW_DONE);
	wire fos_word_t rds_view = {20'h00000, rd_lat_reg, 6'h00, rd_hit_reg, rd_busy_reg};
	wire logic ar_hit = (ar_a == `FOS_ADDR_MCW) | (ar_a == `FOS_ADDR_UTW) | (ar_a == `FOS_ADDR_RCW)
		| (ar_a == `FOS_ADDR_RDA) | (ar_a == `FOS_ADDR_RDS);
	wire fos_word_t rd_mux = (ar_a == `FOS_ADDR_MCW) ? mcw_view :
		(ar_a == `FOS_ADDR_UTW) ? utw_view :
		(ar_a == `FOS_ADDR_RCW) ? rcw_reg :
		(ar_a == `FOS_ADDR_RDA) ? rda_reg :
		(ar_a == `FOS_ADDR_RDS) ? rds_view : 32'h00000000;

	// AXI4-Lite channel handshakes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= `FOS_RESP_OKAY;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			if (aw_taken) begin
				awaddr_reg <= {s_axi_awaddr[11:2], 2'b00};
				awready_reg <= 1'b0;
			end
			if (w_taken) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				wready_reg <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? `FOS_RESP_OKAY : `FOS_RESP_DECERR;
			end
			if (bvalid_reg & s_axi_bready) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `FOS_RESP_OKAY;
		end else if (ar_taken) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= ar_hit ? `FOS_RESP_OKAY : `FOS_RESP_DECERR;
		end else if (rvalid_reg & s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// Control words and sequencer state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mcw_reg <= 32'h00000000;
			utw_reg <= 32'h00000000;
			rcw_reg <= `FOS_RCW_RESET;
			rda_reg <= 32'h00000000;
			op_reg <= FOS_OP_IDLE;
			ck_reg <= FOS_CK_IDLE;
			op_done_reg <= 1'b1;
			ck_done_reg <= 1'b1;
			ready_reg <= 1'b1;
			lpr_reg <= 13'h0000;
		end else begin
			mcw_reg <= mcw_next;
			utw_reg <= utw_next;
			rcw_reg <= rcw_next;
			rda_reg <= rda_next;
			op_reg <= op_next;
			ck_reg <= ck_next;
			op_done_reg <= op_done_next;
			ck_done_reg <= ck_done_next;
			ready_reg <= ready_next;
			lpr_reg <= lpr_next;
		end
	end

	// Read engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tag_reg <= 28'h0000000;
			tag_valid_reg <= 1'b0;
			rd_busy_reg <= 1'b0;
			rd_hit_reg <= 1'b0;
			rd_cnt_reg <= 4'h0;
			rd_lat_reg <= 4'h0;
		end else if (rd_start) begin
			rd_busy_reg <= 1'b1;
			rd_hit_reg <= rd_hit;
			rd_lat_reg <= rd_lat;
			rd_cnt_reg <= rd_lat;
		end else if (rd_busy_reg) begin
			rd_cnt_reg <= rd_cnt_reg - 4'h1;
			if (rd_cnt_reg == 4'h1) begin
				rd_busy_reg <= 1'b0;
				tag_reg <= rda_reg[31:4];
				tag_valid_reg <= 1'b1;
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign op_done = op_done_reg;
	assign check_done = ck_done_reg;
	assign flash_ready = ready_reg;
endmodule

// file: verif/fos_monitor.sv
/*
 Checker for the flag timing of the flash operation sequencer.
 Assumes it is bound to fos_top and that aclk runs at 100 MHz.
*/
`include "fos_consts.svh"

module fos_monitor #(
	parameter int LPR_CYC = 20
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire fos_pkg::fos_word_t s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic op_done,
	input wire logic check_done,
	input wire logic flash_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	import fos_pkg::*;
	logic [11:0] a_q;
	fos_word_t d_q, mcw_q, utw_q;
	logic [15:0] n_m, n_u;
	logic [3:0] km;
	logic [1:0] ku;
	logic bv_q, od_q, cd_q, fr_q;
	wire wr_m = s_axi_bvalid && !bv_q && a_q == `FOS_ADDR_MCW;
	wire wr_u = s_axi_bvalid && !bv_q && a_q == `FOS_ADDR_UTW;
	wire ck_stop = !cd_q && ((utw_q[0] && !d_q[0]) || (!utw_q[1] && d_q[1]));

	// Write capture, event kinds and cycle counts since each write
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata;
		bv_q <= aresetn && s_axi_bvalid;
		od_q <= op_done;
		cd_q <= check_done;
		fr_q <= flash_ready;
		n_m <= !aresetn ? 16'hFFFF : wr_m ? 16'h1 : n_m + {15'h0, ~&n_m};
		n_u <= !aresetn ? 16'hFFFF : wr_u ? 16'h1 : n_u + {15'h0, ~&n_u};
		if (!aresetn || wr_m) mcw_q <= aresetn ? d_q : 32'h0;
		if (!aresetn || wr_u) utw_q <= aresetn ? d_q : 32'h0;
		if (!aresetn || wr_m) km <= !aresetn ? 4'h0 : {mcw_q[4] & !d_q[4], !od_q & mcw_q[0] & !d_q[0],
			!od_q & d_q[2] & !mcw_q[2], !od_q & d_q[1] & !mcw_q[1]};
		if (!aresetn || wr_u) ku <= !aresetn ? 2'h0 : {d_q[3], ck_stop};
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	hv_start_a: assert property (wr_m && d_q[0] && !mcw_q[0] && od_q && flash_ready |-> !op_done)
		else $error("op_done still high after start");
	psus_done_a: assert property (km[0] && n_m == `FOS_PSUS_CYC |-> op_done && !od_q)
		else $error("program suspend done at wrong time");
	esus_done_a: assert property (km[1] && n_m == `FOS_ESUS_CYC |-> op_done && !od_q)
		else $error("erase suspend done at wrong time");
	abort_done_a: assert property (km[2] && n_m == `FOS_ABORT_CYC |-> op_done && !od_q)
		else $error("abort done at wrong time");
	resume_clear_a: assert property (wr_m && od_q && mcw_q[0] && d_q[0] && |mcw_q[2:1] && ~|d_q[2:1] |-> !op_done)
		else $error("op_done still high after resume");
	lpr_ready_a: assert property (km[3] && n_m == LPR_CYC |-> flash_ready && !fr_q)
		else $error("ready at wrong time after low power");
	ck_start_a: assert property (wr_u && cd_q && d_q[0] && !d_q[1] && (!utw_q[0] || utw_q[1]) |-> !check_done)
		else $error("check_done still high after start");
	ai_stop_a: assert property (ku == 2'h1 && n_u == `FOS_AISTOP_CYC |-> check_done && !cd_q)
		else $error("integrity stop done at wrong time");
	mr_stop_a: assert property (ku == 2'h3 && n_u == `FOS_MRSTOP_CYC |-> check_done && !cd_q)
		else $error("margin stop done at wrong time");

	cover property (km[0] && n_m == `FOS_PSUS_CYC);
	cover property (ku == 2'h3 && n_u == `FOS_MRSTOP_CYC);
	cover property (km[3] && n_m == LPR_CYC);
endmodule

bind fos_top fos_monitor #(.LPR_CYC(LPR_CYC)) mon (
	.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .op_done, .check_done, .flash_ready
);

// file: verif/fos_top_tb.sv
/*
 Self-checking bench for the flash operation sequencer over AXI4-Lite.
 Assumes fos_top, its constants header and the bound checker.
*/
`include "fos_consts.svh"

module fos_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fos_pkg::*;
	localparam int LPR = 20;
	localparam logic [11:0] MCW = `FOS_ADDR_MCW;
	localparam logic [11:0] UTW = `FOS_ADDR_UTW;
	localparam logic [11:0] RCW = `FOS_ADDR_RCW;
	localparam logic [11:0] RDA = `FOS_ADDR_RDA;
	localparam logic [11:0] RDS = `FOS_ADDR_RDS;
	localparam logic [1:0] OK = `FOS_RESP_OKAY;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic op_done, check_done, flash_ready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	fos_word_t s_axi_wdata, s_axi_rdata;
	int err_total, cmp_count;
	int ws[3] = '{0, 2, 3};
	int ap[3] = '{0, 1, 1};
	int lat[3] = '{3, 5, 6};

	fos_top #(.LPR_CYC(LPR)) dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.op_done, .check_done, .flash_ready
	);

	task automatic chk(input fos_word_t g, input fos_word_t e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic stop_test();
		if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input fos_word_t d, input logic [1:0] e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, e);
		@(posedge aclk);
	endtask

	task automatic rd(input logic [11:0] a, output fos_word_t d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rc(input logic [11:0] a, input fos_word_t e);
		fos_word_t d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask

	// Poll the read status until idle, then compare hit and latency
	task automatic rs(input fos_word_t e);
		fos_word_t d;
		logic [1:0] r;
		d = 32'h1;
		for (int n = 0; n < 20 && d[0] !== 1'b0; n++) rd(RDS, d, r);
		chk(d & 32'hF03, e);
	endtask

	function automatic logic fl(input int s);
		return s == 0 ? op_done : (s == 1 ? check_done : flash_ready);
	endfunction

	task automatic wt(input int s, input int lim);
		int n;
		n = 0;
		while (fl(s) !== 1'b1 && n < lim) begin
			@(posedge aclk);
			n++;
		end
		chk(fl(s), 1'b1);
	endtask

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	initial begin
		repeat (40000) @(posedge aclk);
		err_total++;
		stop_test();
	end

	initial begin
		fos_word_t d;
		logic [1:0] r;
		err_total = 0;
		cmp_count = 0;
		aresetn <= 1'b0;
		s_axi_awaddr <= 12'h0;
		s_axi_awvalid <= 1'b0;
		s_axi_wdata <= 32'h0;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_araddr <= 12'h0;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rc(MCW, 32'h300);
		rc(UTW, 32'h100);
		rd(12'h0FC, d, r);
		chk(r, 2'h3);
		chk(d, 32'h0);
		wr(12'h0F0, 32'h0, 2'h3);
		wr(MCW, 32'h1, OK);
		chk(op_done, 1'b0);
		repeat (50) @(posedge aclk);
		wr(MCW, 32'h3, OK);
		wt(0, 1154);
		wr(MCW, 32'h1, OK);
		chk(op_done, 1'b0);
		wr(MCW, 32'h0, OK);
		wt(0, 2084);
		wr(MCW, 32'h9, OK);
		repeat (50) @(posedge aclk);
		wr(MCW, 32'hD, OK);
		wt(0, 2084);
		wr(MCW, 32'h0, OK);
		chk(op_done, 1'b1);
		wr(MCW, 32'h1, OK);
		wt(0, 2100);
		wr(MCW, 32'h10, OK);
		chk(flash_ready, 1'b0);
		wr(MCW, 32'h11, OK);
		chk(op_done, 1'b1);
		wr(MCW, 32'h0, OK);
		wt(2, LPR + 7);
		wr(UTW, 32'h1, OK);
		chk(check_done, 1'b0);
		repeat (20) @(posedge aclk);
		wr(UTW, 32'h3, OK);
		wt(1, 23);
		wr(UTW, 32'h1, OK);
		chk(check_done, 1'b0);
		wr(UTW, 32'h0, OK);
		wt(1, 23);
		wr(UTW, 32'h9, OK);
		repeat (20) @(posedge aclk);
		wr(UTW, 32'h8, OK);
		wt(1, 2046);
		for (int i = 0; i < 3; i++) begin
			wr(RCW, 32'(ap[i] * 16 + ws[i]), OK);
			wr(RDA, 32'(i * 64 + 256), OK);
			rs(32'(lat[i] * 256));
			wr(RDA, 32'(i * 64 + 260), OK);
			rs(32'h102);
		end
		stop_test();
	end
endmodule
